// *** pkg/aphp_if.sv ***
// Pin bundle joining the host controller and the device port
`timescale 1ns/1ps
interface aphp_if;
    import aphp_pkg::*;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic ale;
    logic reset_n;
    logic [APHP_AW-1:0] addr;
    logic [APHP_DW-1:0] data_host_out;
    logic data_host_oe;
    logic [APHP_DW-1:0] data_dev_out;
    logic data_dev_oe;
    logic irq_drive_low;
    logic irq_out_n;
    logic [APHP_DW-1:0] data_bus;
    // Shared bus level resolved from the two enables; pull-up where nobody drives
    assign data_bus = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hff);
    assign irq_out_n = irq_drive_low ? 1'b0 : 1'b1;
    modport device (
        input chip_select_n,
        input read_strobe_n,
        input write_strobe_n,
        input ale,
        input reset_n,
        input addr,
        input data_bus,
        output data_dev_out,
        output data_dev_oe,
        output irq_drive_low
    );
    modport host (
        output chip_select_n,
        output read_strobe_n,
        output write_strobe_n,
        output ale,
        output reset_n,
        output addr,
        output data_host_out,
        output data_host_oe,
        input data_bus,
        input irq_out_n
    );
endinterface

// *** pkg/aphp_pkg.sv ***
// Shared constants of the asynchronous parallel host port
package aphp_pkg;
    localparam int APHP_DW = 8;
    localparam int APHP_AW = 8;
    localparam int APHP_NREG = 256;
    localparam int APHP_NIRQ = 8;
    localparam logic [7:0] APHP_DATA_RST = 8'h00;
    localparam logic [7:0] APHP_ADDR_RST = 8'h00;
    // Register that holds the test-mode bits cleared on a chip deselect
    localparam logic [7:0] APHP_TEST_ADDR = 8'hff;
    localparam logic [7:0] APHP_TEST_RST = 8'h00;
    // Host timing, in clock cycles of the host controller
    localparam int APHP_SETUP_CYC = 2;
    localparam int APHP_STROBE_CYC = 3;
    localparam int APHP_HOLD_CYC = 1;
    localparam logic [3:0] APHP_CNT_ONE = 4'h1;
endpackage

// *** src/aphp_addr_latch.sv ***
// Transparent address latch, held while latch enable is low
`timescale 1ns/1ps
module aphp_addr_latch
    import aphp_pkg::*;
(
    input wire logic reset_n,
    input wire logic ale,
    input wire logic [APHP_AW-1:0] addr_in,
    output logic [APHP_AW-1:0] addr_held
);
    // Level-sensitive on purpose: multiplexed buses need the address kept after ALE falls
    always_latch begin
        if (!reset_n) begin
            addr_held = APHP_ADDR_RST;
        end else if (ale) begin
            addr_held = addr_in;
        end
    end
endmodule

// *** src/aphp_device.sv ***
// Device end: strobe-timed register file, data bus driver, interrupt output
// How it works
// - Unmasked pending event pulls interrupt low
// - Interrupt stays low until sources acknowledged
// - Strobes ignored while chip select high
// - Host ties chip select high when unused
// - Chip select high clears test modes
// - One shared 8-bit bidirectional data bus
// - Drive addressed register while read active
// - Capture data on write strobe rising edge
// - Address latch transparent while enable high
// - Latched address selects the register
// - Reset input clears device asynchronously
`timescale 1ns/1ps
module aphp_device
    import aphp_pkg::*;
(
    aphp_if.device bus,
    input wire logic [APHP_NIRQ-1:0] irq_event,
    input wire logic [APHP_NIRQ-1:0] irq_mask,
    input wire logic [APHP_NIRQ-1:0] irq_ack,
    output logic [APHP_NIRQ-1:0] irq_pending,
    output logic [APHP_DW-1:0] test_mode
);
    logic [APHP_AW-1:0] addr_held;
    logic [APHP_DW-1:0] regs [APHP_NREG];
    logic wr_clk;
    logic read_active;

    // Test-mode register decode, shared by register write, test-mode write and read paths
    function automatic logic aphp_is_test(input logic [APHP_AW-1:0] a);
        return a == APHP_TEST_ADDR;
    endfunction

    ////////////////////////////////////////////////////////////////
    aphp_addr_latch u_latch (
        .reset_n(bus.reset_n),
        .ale(bus.ale),
        .addr_in(bus.addr),
        .addr_held(addr_held)
    );

    ////////////////////////////////////////////////////////////////
    // Writes are clocked by the strobe itself; the port has no bus clock
    assign wr_clk = bus.write_strobe_n | bus.chip_select_n;

    always_ff @(posedge wr_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            for (int i = 0; i < APHP_NREG; i++) begin
                regs[i] <= APHP_DATA_RST;
            end
        end else if (!aphp_is_test(addr_held)) begin
            regs[addr_held] <= bus.data_bus;
        end
    end

    // Test modes are written like a register but dropped whenever chip select rises
    always_ff @(posedge wr_clk or posedge bus.chip_select_n or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            test_mode <= APHP_TEST_RST;
        end else if (bus.chip_select_n) begin
            test_mode <= APHP_TEST_RST;
        end else if (aphp_is_test(addr_held)) begin
            test_mode <= bus.data_bus;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign read_active = !bus.read_strobe_n && !bus.chip_select_n;
    assign bus.data_dev_oe = read_active;
    assign bus.data_dev_out = aphp_is_test(addr_held) ? test_mode : regs[addr_held];

    ////////////////////////////////////////////////////////////////
    // Sticky per source, built from two edge flops so that neither edge looks at the
    // other input's level: an ack clears the bit even while the event line stays high.
    // Limitation: an ack in the very instant of a fresh event on a pending bit loses it.
    for (genvar g = 0; g < APHP_NIRQ; g++) begin : g_irq
        logic set_tog;
        logic clr_tog;
        always_ff @(posedge irq_event[g] or negedge bus.reset_n) begin
            if (!bus.reset_n) begin
                set_tog <= 1'b0;
            end else begin
                set_tog <= ~clr_tog;
            end
        end
        always_ff @(posedge irq_ack[g] or negedge bus.reset_n) begin
            if (!bus.reset_n) begin
                clr_tog <= 1'b0;
            end else begin
                clr_tog <= set_tog;
            end
        end
        assign irq_pending[g] = set_tog ^ clr_tog;
    end

    assign bus.irq_drive_low = |(irq_pending & ~irq_mask);
endmodule

// *** src/aphp_host.sv ***
// Host end: sequences chip select, strobes, address and data on the pins
`timescale 1ns/1ps
module aphp_host
    import aphp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    aphp_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [APHP_AW-1:0] req_addr,
    input wire logic [APHP_DW-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [APHP_DW-1:0] rsp_rdata,
    output logic irq
);
    typedef enum logic [3:0] {
        APHP_IDLE = 4'b0001,
        APHP_SETUP = 4'b0010,
        APHP_STROBE = 4'b0100,
        APHP_HOLD = 4'b1000
    } aphp_state_t;

    aphp_state_t state;
    logic [3:0] cnt;
    logic is_write;

    function automatic logic [3:0] aphp_cyc(input int n);
        aphp_cyc = 4'(n);
    endfunction

    ////////////////////////////////////////////////////////////////
    assign req_ready = (state == APHP_IDLE) && !rst;
    assign bus.reset_n = !rst;
    assign irq = !bus.irq_out_n;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= APHP_IDLE;
            cnt <= 4'h0;
        end else begin
            unique case (state)
                APHP_IDLE: begin
                    if (req_valid) begin
                        state <= APHP_SETUP;
                        cnt <= aphp_cyc(APHP_SETUP_CYC);
                    end
                end
                APHP_SETUP: begin
                    cnt <= cnt - APHP_CNT_ONE;
                    if (cnt == APHP_CNT_ONE) begin
                        state <= APHP_STROBE;
                        cnt <= aphp_cyc(APHP_STROBE_CYC);
                    end
                end
                APHP_STROBE: begin
                    cnt <= cnt - APHP_CNT_ONE;
                    if (cnt == APHP_CNT_ONE) begin
                        state <= APHP_HOLD;
                        cnt <= aphp_cyc(APHP_HOLD_CYC);
                    end
                end
                APHP_HOLD: begin
                    cnt <= cnt - APHP_CNT_ONE;
                    if (cnt == APHP_CNT_ONE) begin
                        state <= APHP_IDLE;
                    end
                end
            endcase
        end
    end

    // Pins are registered so strobes never glitch
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.chip_select_n <= 1'b1;
            bus.read_strobe_n <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            bus.ale <= 1'b0;
            bus.addr <= APHP_ADDR_RST;
            bus.data_host_out <= APHP_DATA_RST;
            bus.data_host_oe <= 1'b0;
            is_write <= 1'b0;
        end else begin
            unique case (state)
                APHP_IDLE: begin
                    bus.chip_select_n <= 1'b1;
                    if (req_valid) begin
                        is_write <= req_write;
                        bus.ale <= 1'b1;
                        bus.addr <= req_addr;
                        bus.data_host_out <= req_wdata;
                        bus.data_host_oe <= req_write;
                    end
                end
                APHP_SETUP: begin
                    bus.chip_select_n <= 1'b0;
                    if (cnt == APHP_CNT_ONE) begin
                        bus.ale <= 1'b0;
                        bus.read_strobe_n <= is_write;
                        bus.write_strobe_n <= !is_write;
                    end
                end
                APHP_STROBE: begin
                    if (cnt == APHP_CNT_ONE) begin
                        bus.read_strobe_n <= 1'b1;
                        bus.write_strobe_n <= 1'b1;
                    end
                end
                APHP_HOLD: begin
                    if (cnt == APHP_CNT_ONE) begin
                        bus.chip_select_n <= 1'b1;
                        bus.data_host_oe <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= APHP_DATA_RST;
        end else begin
            rsp_valid <= (state == APHP_STROBE) && (cnt == APHP_CNT_ONE) && !is_write;
            if ((state == APHP_STROBE) && (cnt == APHP_CNT_ONE) && !is_write) begin
                rsp_rdata <= bus.data_bus;
            end
        end
    end
endmodule

// *** verif/aphp_assertions.sv ***
// Pin-level checks on the link between host and device ends
`timescale 1ns/1ps
module aphp_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic ale,
    input wire logic data_host_oe,
    input wire logic data_dev_oe,
    input wire logic irq_drive_low,
    input wire logic irq_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd_pulse;
        !read_strobe_n [*3] ##1 read_strobe_n;
    endsequence
    sequence s_wr_pulse;
        !write_strobe_n [*3] ##1 write_strobe_n;
    endsequence
    AST_RD_DRIVE: assert property (data_dev_oe == (!chip_select_n && !read_strobe_n))
        else $error("device drives bus outside a read");
    AST_RD_LEN: assert property ($fell(read_strobe_n) |-> s_rd_pulse)
        else $error("read strobe length off");
    AST_WR_LEN: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
        else $error("write strobe length off");
    AST_CS_GATE: assert property ((!read_strobe_n || !write_strobe_n) |-> !chip_select_n)
        else $error("strobe without chip select");
    AST_WR_CAPTURE: assert property ($rose(write_strobe_n) |-> !chip_select_n ##[1:2] chip_select_n)
        else $error("write edge not framed by chip select");
    AST_ALE_HOLD: assert property ((!read_strobe_n || !write_strobe_n) |-> !ale)
        else $error("address latch open during strobe");
    AST_BUS_ONE: assert property (!read_strobe_n |-> !data_host_oe)
        else $error("both ends drive the bus");
    AST_SETUP: assert property ($fell(chip_select_n) |-> ##[1:4] (!read_strobe_n || !write_strobe_n))
        else $error("no strobe after chip select");
    AST_RST_IDLE: assert property ($fell(rst) |-> chip_select_n && !irq_drive_low && irq_out_n)
        else $error("state left after reset");
endmodule

// *** verif/tb_async_parallel_host_port.sv ***
// Bench joining host and device ends over the pin bundle
`timescale 1ns/1ps
module tb_async_parallel_host_port;
    import aphp_pkg::*;
    logic clk, rst, req_valid, req_write, req_ready, rsp_valid, irq;
    logic [7:0] req_addr, req_wdata, rsp_rdata, test_mode, a;
    logic [7:0] irq_event, irq_mask, irq_ack, irq_pending;
    logic [7:0] mem [256];
    logic [7:0] exp_q [$];
    int err_total, n_checks, cyc;
    aphp_if u_aphp_if ();
    aphp_host u_aphp_host (.clk, .rst, .bus(u_aphp_if.host), .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .irq);
    aphp_device u_aphp_device (.bus(u_aphp_if.device), .irq_event, .irq_mask, .irq_ack,
        .irq_pending, .test_mode);
    aphp_assertions u_aphp_assertions (.clk, .rst, .chip_select_n(u_aphp_if.chip_select_n),
        .read_strobe_n(u_aphp_if.read_strobe_n), .write_strobe_n(u_aphp_if.write_strobe_n),
        .ale(u_aphp_if.ale), .data_host_oe(u_aphp_if.data_host_oe),
        .data_dev_oe(u_aphp_if.data_dev_oe), .irq_drive_low(u_aphp_if.irq_drive_low),
        .irq_out_n(u_aphp_if.irq_out_n));
    ////////////////////////////////////////////////////////////////
    task chk_data(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: data %h not %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: irq %b not %b", $time, got, exp);
        end
    endtask
    // Ready is sampled mid-cycle so its comb settling never races the edge
    task acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            $display("wrong value at %0t: host never ready", $time);
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_wdata <= d;
        if (w && ad != APHP_TEST_ADDR) mem[ad] = d;
        if (!w) exp_q.push_back(mem[ad]);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task irq_step(input logic [7:0] m, input logic [7:0] e, input logic [7:0] k,
        input logic [7:0] p, input logic x);
        @(posedge clk);
        irq_mask <= m;
        irq_event <= e;
        irq_ack <= k;
        repeat (3) @(negedge clk);
        chk_bit(irq, x);
        chk_data(irq_pending, p);
    endtask
    task end_test(input string s);
        $display("test %s done", s);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    always @(negedge clk) begin
        if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
            chk_data(rsp_rdata, exp_q.pop_front());
        end else if (rsp_valid === 1'b1) begin
            err_total++;
            $display("wrong value at %0t: response with nothing expected", $time);
        end
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        irq_event = 8'h00;
        irq_mask = 8'hff;
        irq_ack = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(19431));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Back-to-back traffic, unwritten places read as cleared
        for (int i = 0; i < 24; i++) begin
            a = 8'($urandom_range(254, 0));
            acc(1'b1, a, 8'($urandom));
            acc(1'b0, a, 8'h00);
            acc(1'b0, 8'($urandom_range(254, 0)), 8'h00);
        end
        end_test("rw");
        acc(1'b1, APHP_TEST_ADDR, 8'h5a);
        // Strobe rises five edges after the take; chip select is still low for one cycle
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk_data(test_mode, 8'h5a);
        repeat (10) @(negedge clk);
        chk_data(test_mode, APHP_TEST_RST);
        acc(1'b0, APHP_TEST_ADDR, 8'h00);
        end_test("test mode");
        irq_step(8'hd7, 8'h04, 8'h00, 8'h04, 1'b0);
        irq_step(8'hd7, 8'h2c, 8'h00, 8'h2c, 1'b1);
        irq_step(8'hd7, 8'h2c, 8'h08, 8'h24, 1'b1);
        irq_step(8'hd7, 8'h2c, 8'h28, 8'h04, 1'b0);
        irq_step(8'h00, 8'h2c, 8'h28, 8'h04, 1'b1);
        irq_step(8'h00, 8'h00, 8'h2c, 8'h00, 1'b0);
        irq_step(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        // Leave one source pending so the reset below has something to clear
        irq_step(8'h00, 8'h01, 8'h00, 8'h01, 1'b1);
        end_test("irq");
        // Reset mid-run wipes the written places
        repeat (10) @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        chk_bit(u_aphp_if.chip_select_n, 1'b1);
        rst <= 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
        acc(1'b0, a, 8'h00);
        repeat (10) @(negedge clk);
        chk_data(irq_pending, 8'h00);
        chk_bit(irq, 1'b0);
        end_test("reset");
        if (exp_q.size() != 0) begin
            err_total++;
            $display("wrong value at %0t: reads left without a response", $time);
        end
        report_and_stop();
    end
endmodule
